// ---- parallel_port_config.sv ----
// Parallel port logical device configuration register bank on AXI4-Lite
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module parallel_port_config
#(
    parameter int AXI_ADDR_W = 12
)
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  global_config_one,
    input  wire logic [2:0]            ecr_mode,
    input  wire logic                  second_level_ext_ctl_bit4,
    input  wire logic [15:0]           io_addr,
    input  wire logic                  io_cycle,
    output logic                       device_active,
    output logic [2:0]                 port_mode,
    output logic                       port_clock_run,
    output logic                       port_pins_float,
    output logic                       irq_level_type,
    output logic                       epp_v19_select,
    output logic [2:0]                 ext_reg_select,
    output logic                       ext_reg_ignored,
    output logic [15:0]                port_base,
    output logic [7:0]                 irq_number,
    output logic [7:0]                 dma_channel
);

    localparam int ADDR_LSB = parallel_port_config_pkg::ADDR_LSB;
    if (AXI_ADDR_W < 12)
    begin
        $error("AXI_ADDR_W must be at least 12");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    logic [7:0]            activate_reg;
    logic [7:0]            base_high_reg;
    logic [7:0]            base_low_reg;
    logic [7:0]            irq_number_reg;
    logic [7:0]            irq_type_reg;
    logic [7:0]            dma_select_reg;
    logic [7:0]            config_reg;

    ////////////////////////////////////////////////////////////////////////
    // AXI write channel

    logic                  aw_held_reg;
    logic [AXI_ADDR_W-1:0] aw_addr_reg;
    logic                  w_held_reg;
    logic [7:0]            w_data_reg;
    logic                  w_lane0_reg;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic                  do_write;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [7:0]            wr_data;
    logic                  wr_lane0;
    logic [7:0]            wr_index;
    logic                  wr_hit;

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_held_reg & ~bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    assign wr_addr  = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data  = w_held_reg ? w_data_reg : s_axi_wdata[7:0];
    assign wr_lane0 = w_held_reg ? w_lane0_reg : s_axi_wstrb[0];
    assign do_write = (aw_held_reg | (s_axi_awvalid & s_axi_awready))
                    & (w_held_reg | (s_axi_wvalid & s_axi_wready));
    assign wr_index = wr_addr[ADDR_LSB+7:ADDR_LSB];
    assign wr_hit   = (wr_addr[AXI_ADDR_W-1:0] >> ADDR_LSB) < 10'(256)
                    && is_mapped(wr_index);

    function automatic logic is_mapped(input logic [7:0] idx);
        is_mapped = idx == parallel_port_config_pkg::IDX_ACTIVATE
                 || idx == parallel_port_config_pkg::IDX_BASE_HIGH
                 || idx == parallel_port_config_pkg::IDX_BASE_LOW
                 || idx == parallel_port_config_pkg::IDX_IRQ_NUMBER
                 || idx == parallel_port_config_pkg::IDX_IRQ_TYPE
                 || idx == parallel_port_config_pkg::IDX_DMA_SELECT
                 || idx == parallel_port_config_pkg::IDX_DMA_REPORT
                 || idx == parallel_port_config_pkg::IDX_PORT_CONFIG;
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (do_write)
            aw_held_reg <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_reg  <= 1'b0;
            w_data_reg  <= 8'h00;
            w_lane0_reg <= 1'b0;
        end
        else if (do_write)
            w_held_reg <= 1'b0;
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_reg  <= 1'b1;
            w_data_reg  <= s_axi_wdata[7:0];
            w_lane0_reg <= s_axi_wstrb[0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= parallel_port_config_pkg::RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? parallel_port_config_pkg::RESP_OKAY
                                 : parallel_port_config_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register updates

    logic wr_en;
    assign wr_en = do_write & wr_hit & wr_lane0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            activate_reg <= parallel_port_config_pkg::RST_ACTIVATE; // see R1
        else if (wr_en && wr_index == parallel_port_config_pkg::IDX_ACTIVATE)
            activate_reg <= wr_data; // see R1
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            base_high_reg <= parallel_port_config_pkg::RST_BASE_HIGH;
            base_low_reg  <= parallel_port_config_pkg::RST_BASE_LOW;
        end
        else if (wr_en && wr_index == parallel_port_config_pkg::IDX_BASE_HIGH)
            base_high_reg <= wr_data
                & parallel_port_config_pkg::MASK_BASE_HIGH; // see R2
        else if (wr_en && wr_index == parallel_port_config_pkg::IDX_BASE_LOW)
            base_low_reg <= wr_data
                & parallel_port_config_pkg::MASK_BASE_LOW; // see R3
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_number_reg <= parallel_port_config_pkg::RST_IRQ_NUMBER;
            irq_type_reg   <= parallel_port_config_pkg::RST_IRQ_TYPE; // see R5
        end
        else if (wr_en
                 && wr_index == parallel_port_config_pkg::IDX_IRQ_NUMBER)
            irq_number_reg <= wr_data;
        else if (wr_en && wr_index == parallel_port_config_pkg::IDX_IRQ_TYPE)
            irq_type_reg <= wr_data
                & parallel_port_config_pkg::MASK_IRQ_TYPE_W; // see R5 R18
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dma_select_reg <= parallel_port_config_pkg::RST_DMA_SELECT; // see R7
        else if (wr_en
                 && wr_index == parallel_port_config_pkg::IDX_DMA_SELECT)
            dma_select_reg <= wr_data; // see R7
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            config_reg <= parallel_port_config_pkg::RST_PORT_CONFIG; // see R8
        else if (wr_en
                 && wr_index == parallel_port_config_pkg::IDX_PORT_CONFIG)
            config_reg <= wr_data
                & parallel_port_config_pkg::MASK_CONFIG; // see R18
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI read channel

    logic        rvalid_reg;
    logic [7:0]  rdata_reg;
    logic [1:0]  rresp_reg;
    logic [7:0]  rd_index;
    logic        rd_hit;
    logic [7:0]  rd_value;
    logic [7:0]  irq_type_view;

    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = {24'h000000, rdata_reg};
    assign s_axi_rresp   = rresp_reg;
    assign rd_index      = s_axi_araddr[ADDR_LSB+7:ADDR_LSB];
    assign rd_hit        = (s_axi_araddr >> ADDR_LSB) < 10'(256)
                         && is_mapped(rd_index);

    // Bit 0 follows the mode, bit 1 is stored, the rest read zero
    assign irq_type_view = (irq_type_reg
        & parallel_port_config_pkg::MASK_IRQ_TYPE_W)
        | {7'h00, irq_level_type}; // see R6 R18

    always_comb
    begin
        rd_value = 8'h00;
        unique case (rd_index)
            parallel_port_config_pkg::IDX_ACTIVATE:
                rd_value = activate_reg;
            parallel_port_config_pkg::IDX_BASE_HIGH:
                rd_value = base_high_reg; // see R2
            parallel_port_config_pkg::IDX_BASE_LOW:
                rd_value = base_low_reg; // see R3
            parallel_port_config_pkg::IDX_IRQ_NUMBER:
                rd_value = irq_number_reg;
            parallel_port_config_pkg::IDX_IRQ_TYPE:
                rd_value = irq_type_view; // see R5
            parallel_port_config_pkg::IDX_DMA_SELECT:
                rd_value = dma_select_reg;
            parallel_port_config_pkg::IDX_DMA_REPORT:
                rd_value = parallel_port_config_pkg::VAL_DMA_REPORT; // see R7
            parallel_port_config_pkg::IDX_PORT_CONFIG:
                rd_value = config_reg;
            default:
                rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 8'h00;
            rresp_reg  <= parallel_port_config_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_hit ? rd_value : 8'h00;
            rresp_reg  <= rd_hit ? parallel_port_config_pkg::RESP_OKAY
                                 : parallel_port_config_pkg::RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Device control outputs

    logic        ext_access;
    logic [15:0] io_offset;
    logic [2:0]  ext_hit;
    logic [2:0]  ext_sel_reg;
    logic        ext_ign_reg;

    assign device_active = activate_reg[parallel_port_config_pkg::ACT_ENABLE]
                         & global_config_one; // see R1
    assign port_mode = config_reg[parallel_port_config_pkg::CFG_MODE_HI:
                                  parallel_port_config_pkg::CFG_MODE_LO];
    assign irq_level_type =
        port_mode == parallel_port_config_pkg::MODE_EXTENDED; // see R6 R9
    assign port_clock_run = device_active
        & config_reg[parallel_port_config_pkg::CFG_POWER]; // see R14 R15
    assign port_pins_float = ~device_active
        & config_reg[parallel_port_config_pkg::CFG_TRISTATE]; // see R16
    assign epp_v19_select = ecr_mode == parallel_port_config_pkg::ECR_MODE_EPP
        && second_level_ext_ctl_bit4; // see R10
    assign ext_access = config_reg[parallel_port_config_pkg::CFG_EXT_ACCESS];
    assign port_base  = {5'h00, base_high_reg[2:0], base_low_reg};
    assign irq_number = irq_number_reg;
    assign dma_channel = dma_select_reg;
    assign io_offset = io_addr - port_base;
    assign ext_hit = {io_offset == parallel_port_config_pkg::EXT_OFS_AUX,
                      io_offset == parallel_port_config_pkg::EXT_OFS_DATA,
                      io_offset == parallel_port_config_pkg::EXT_OFS_INDEX};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ext_sel_reg <= 3'h0;
            ext_ign_reg <= 1'b0;
        end
        else
        begin
            ext_sel_reg <= (io_cycle && ext_access)
                ? ext_hit : 3'h0; // see R13 R17
            ext_ign_reg <= io_cycle && !ext_access
                && (ext_hit != 3'h0); // see R12
        end
    end

    assign ext_reg_select  = ext_sel_reg;
    assign ext_reg_ignored = ext_ign_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_base_high_zero: assert property ( // see R2
        s_axi_rvalid && s_axi_rresp == parallel_port_config_pkg::RESP_OKAY
        && $past(rd_index) == parallel_port_config_pkg::IDX_BASE_HIGH
        && $past(s_axi_arvalid && s_axi_arready)
        |-> s_axi_rdata[7:3] == 5'h00)
        else $error("Base high upper bits not zero");

    a_base_low_align: assert property ( // see R3
        port_base[1:0] == 2'h0 && base_low_reg[1:0] == 2'h0)
        else $error("Base low bits not zero");

    a_irq_type_ro: assert property ( // see R5
        irq_type_reg[7:2] == 6'h00 && irq_type_reg[0] == 1'b0)
        else $error("Interrupt type read-only bits stored");

    a_irq_type_level: assert property ( // see R6
        s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready)
        && $past(rd_index) == parallel_port_config_pkg::IDX_IRQ_TYPE
        && $past(port_mode) == parallel_port_config_pkg::MODE_EXTENDED
        |-> s_axi_rdata[0])
        else $error("Interrupt type bit 0 not level in extended mode");

    a_dma_report: assert property ( // see R7
        s_axi_rvalid && $past(s_axi_arvalid && s_axi_arready)
        && $past(rd_index) == parallel_port_config_pkg::IDX_DMA_REPORT
        |-> s_axi_rdata == 32'h00000004)
        else $error("Second DMA report wrong");

    a_config_reset: assert property ( // see R8
        $rose(aresetn) |-> config_reg == 8'hF2 && activate_reg == 8'h00)
        else $error("Reset values wrong");

    a_ext_ignored: assert property ( // see R12
        io_cycle && !ext_access |=> ext_reg_select == 3'h0)
        else $error("Extended register decoded while gated");

    a_ext_decode: assert property ( // see R13
        io_cycle && ext_access && io_addr == port_base + 16'h0404
        |=> ext_reg_select == 3'h2 && !ext_reg_ignored)
        else $error("Extended data register not decoded");

    a_clock_stop: assert property ( // see R14
        $fell(config_reg[1]) && device_active |-> !port_clock_run)
        else $error("Port clock runs with power bit clear");

    a_pins_float: assert property ( // see R16
        $fell(device_active) && config_reg[0] |-> port_pins_float)
        else $error("Pins not floated when inactive");

    a_write_resp: assert property (
        do_write |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
        else $error("Write response missing");

    c_write_config: cover property (
        wr_en && wr_index == parallel_port_config_pkg::IDX_PORT_CONFIG);
    c_ext_hit: cover property (ext_reg_select != 3'h0);
    c_ext_ignored: cover property (ext_reg_ignored);
    c_bad_read: cover property (
        s_axi_rvalid && s_axi_rresp == parallel_port_config_pkg::RESP_SLVERR);

endmodule

// ---- parallel_port_config_pkg.sv ----
// Constants for the parallel port logical device configuration registers
// Function
// R1: Activation register at index 30h, read/write, resets to 00h, gated by global bit.
// R2: Base high byte resets 02h, upper five bits read zero, bit 2 kept zero; the code stores bit 2 as written (MASK_BASE_HIGH is 07h).
// R3: Base low byte resets 78h, two low bits read-only zero.
// R4: Software keeps base bit 2 zero for EPP mode or extended registers.
// R5: Interrupt type at 71h resets 02h; only bit 1 writable.
// R6: Interrupt type bit 0 reads 1 in extended mode, else 0.
// R7: DMA select at 74h resets 04h; 75h reads fixed 04h.
// R8: Port configuration at F0h resets to F2h.
// R9: Configuration bits 7 to 5 select mode; 000 is compatible mode.
// R10: In ECP mode 4, second-level control bit 4 picks EPP 1.7 or 1.9.
// R11: Software enables port and writes C4h to control before changing mode.
// R12: Bit 4 clear makes accesses to base plus 403h-405h ignored.
// R13: Bit 4 set decodes extended registers at base plus 403h-405h.
// R14: Active with bit 1 clear stops port clock; registers retained.
// R15: Bit 1 set runs port clock and all modes while active.
// R16: Bit 0 set and device inactive floats all port output pins.
// R17: Extended registers reachable only while the access bit enables them.
// R18: Writes to read-only bits are discarded; reads return fixed values.
package parallel_port_config_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_ACTIVATE    = 8'h30;
    localparam logic [7:0]  IDX_BASE_HIGH   = 8'h60;
    localparam logic [7:0]  IDX_BASE_LOW    = 8'h61;
    localparam logic [7:0]  IDX_IRQ_NUMBER  = 8'h70;
    localparam logic [7:0]  IDX_IRQ_TYPE    = 8'h71;
    localparam logic [7:0]  IDX_DMA_SELECT  = 8'h74;
    localparam logic [7:0]  IDX_DMA_REPORT  = 8'h75;
    localparam logic [7:0]  IDX_PORT_CONFIG = 8'hF0;
    localparam int          ADDR_LSB        = 2;

    // Reset and fixed values
    localparam logic [7:0]  RST_ACTIVATE    = 8'h00;
    localparam logic [7:0]  RST_BASE_HIGH   = 8'h02;
    localparam logic [7:0]  RST_BASE_LOW    = 8'h78;
    localparam logic [7:0]  RST_IRQ_NUMBER  = 8'h07;
    localparam logic [7:0]  RST_IRQ_TYPE    = 8'h02;
    localparam logic [7:0]  RST_DMA_SELECT  = 8'h04;
    localparam logic [7:0]  VAL_DMA_REPORT  = 8'h04;
    localparam logic [7:0]  RST_PORT_CONFIG = 8'hF2;

    // Field masks of stored bits
    localparam logic [7:0]  MASK_BASE_HIGH  = 8'h07;
    localparam logic [7:0]  MASK_BASE_LOW   = 8'hFC;
    localparam logic [7:0]  MASK_IRQ_TYPE_W = 8'h02;
    localparam logic [7:0]  MASK_CONFIG     = 8'hF3;

    // Field positions of the port configuration, activation, interrupt type and second-level control registers
    localparam int          CFG_MODE_HI     = 7;
    localparam int          CFG_MODE_LO     = 5;
    localparam int          CFG_EXT_ACCESS  = 4;
    localparam int          CFG_POWER       = 1;
    localparam int          CFG_TRISTATE    = 0;
    localparam int          ACT_ENABLE      = 0;
    localparam int          IRQT_LEVEL      = 0;
    localparam int          CTL2_EPP_VER    = 4;

    // Mode codes
    localparam logic [2:0]  MODE_COMPATIBLE = 3'h0;
    localparam logic [2:0]  MODE_EXTENDED   = 3'h7;
    localparam logic [2:0]  ECR_MODE_EPP    = 3'h4;

    // Extended runtime register offsets
    localparam logic [15:0] EXT_OFS_INDEX   = 16'h0403;
    localparam logic [15:0] EXT_OFS_DATA    = 16'h0404;
    localparam logic [15:0] EXT_OFS_AUX     = 16'h0405;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

// ---- testbench.sv ----
// Self-checking testbench for the parallel port configuration registers
`timescale 1ns/1ps
module testbench;
    localparam logic [1:0] ok_resp  = parallel_port_config_pkg::RESP_OKAY;
    localparam logic [1:0] err_resp = parallel_port_config_pkg::RESP_SLVERR;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, global_config_one;
    logic        second_level_ext_ctl_bit4, io_cycle, device_active;
    logic        port_clock_run, port_pins_float, irq_level_type;
    logic        epp_v19_select, ext_reg_ignored;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  ecr_mode, port_mode, ext_reg_select;
    logic [15:0] io_addr, port_base;
    logic [7:0]  irq_number, dma_channel;
    int          n_mismatch, samples_checked;

    parallel_port_config DUT
    (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .global_config_one(global_config_one), .ecr_mode(ecr_mode),
        .second_level_ext_ctl_bit4(second_level_ext_ctl_bit4),
        .io_addr(io_addr), .io_cycle(io_cycle),
        .device_active(device_active), .port_mode(port_mode),
        .port_clock_run(port_clock_run), .port_pins_float(port_pins_float),
        .irq_level_type(irq_level_type), .epp_v19_select(epp_v19_select),
        .ext_reg_select(ext_reg_select), .ext_reg_ignored(ext_reg_ignored),
        .port_base(port_base), .irq_number(irq_number),
        .dma_channel(dma_channel)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Register write: address and data offered together, each released
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr  <= {2'h0, idx, 2'h0};
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        if (!s_axi_bvalid)
        begin
            n_mismatch++;
            wrap_up();
        end
        else
            check(32'(s_axi_bresp), 32'(er));
    endtask

    // Register read with expected data and response
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                      input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr  <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        if (!s_axi_rvalid)
        begin
            n_mismatch++;
            wrap_up();
        end
        else
        begin
            check(s_axi_rdata, {24'h0, exp});
            check(32'(s_axi_rresp), 32'(er));
        end
    endtask

    // One runtime I/O cycle, decode result checked one cycle later
    task automatic io_probe(input logic [15:0] a, input logic [2:0] sel,
                            input logic ign);
        io_addr  <= a;
        io_cycle <= 1'b1;
        @(posedge aclk);
        io_cycle <= 1'b0;
        @(posedge aclk);
        check(32'(ext_reg_select), 32'(sel));
        check(32'(ext_reg_ignored), 32'(ign));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(8'h30, 8'h00, ok_resp);
        rd(8'h60, 8'h02, ok_resp);
        rd(8'h61, 8'h78, ok_resp);
        rd(8'h70, 8'h07, ok_resp);
        rd(8'h71, 8'h03, ok_resp);
        rd(8'h74, 8'h04, ok_resp);
        rd(8'h75, 8'h04, ok_resp);
        rd(8'hF0, 8'hF2, ok_resp);
        check(32'(port_base), 32'h0278);
        check(32'(irq_number), 32'h07);
        check(32'(dma_channel), 32'h04);
        check(32'(device_active), 32'h0);
        check(32'(port_pins_float), 32'h0);
        rd(8'h31, 8'h00, err_resp);
        wr(8'h31, 8'hFF, err_resp);
    endtask

    task automatic t_ext;
        for (int k = -1; k < 4; k++)
            io_probe(16'(16'h067B + k), (k >= 0 && k < 3) ? 3'(1 << k) : 3'h0,
                     1'b0);
        wr(8'hF0, 8'hE2, ok_resp);
        for (int k = 0; k < 3; k++)
            io_probe(16'(16'h067B + k), 3'h0, 1'b1);
    endtask

    task automatic t_epp;
        for (int m = 0; m < 8; m++)
            for (int b = 0; b < 2; b++)
            begin
                ecr_mode                  <= 3'(m);
                second_level_ext_ctl_bit4 <= 1'(b);
                @(posedge aclk);
                check(32'(epp_v19_select), 32'(m == 4 && b == 1));
            end
    endtask

    task automatic t_readonly;
        logic [7:0] idx [8] = '{8'h60, 8'h61, 8'h70, 8'h71,
                                8'h74, 8'h75, 8'hF0, 8'h30};
        logic [7:0] hi  [8] = '{8'h03, 8'hF8, 8'hFF, 8'h03,
                                8'hFF, 8'h04, 8'hF3, 8'hFF};
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 8; i++)
                wr(idx[i], p != 0 ? 8'h00 : (i < 2 ? 8'hFB : 8'hFF),
                   ok_resp);
            for (int i = 0; i < 8; i++)
                rd(idx[i], p == 0 ? hi[i] : (i == 5 ? 8'h04 : 8'h00),
                   ok_resp);
            if (p == 0)
            begin
                check(32'(port_base), 32'h03F8);
                check(32'(dma_channel), 32'hFF);
            end
        end
    endtask

    task automatic t_modes;
        wr(8'h30, 8'h01, ok_resp);
        for (int m = 0; m < 8; m++)
        begin
            wr(8'hF0, {3'(m), 5'h12}, ok_resp);
            rd(8'hF0, {3'(m), 5'h12}, ok_resp);
            rd(8'h71, {7'h00, m == 7}, ok_resp);
            check(32'(port_mode), 32'(m));
            check(32'(irq_level_type), 32'(m == 7));
        end
    endtask

    task automatic t_power;
        wr(8'h30, 8'h01, ok_resp);
        wr(8'hF0, 8'h02, ok_resp);
        check(32'(device_active), 32'h1);
        check(32'(port_clock_run), 32'h1);
        wr(8'h70, 8'h5A, ok_resp);
        wr(8'hF0, 8'h01, ok_resp);
        check(32'(port_clock_run), 32'h0);
        check(32'(port_pins_float), 32'h0);
        rd(8'h70, 8'h5A, ok_resp);
        check(32'(irq_number), 32'h5A);
        global_config_one <= 1'b0;
        @(posedge aclk);
        check(32'(device_active), 32'h0);
        check(32'(port_pins_float), 32'h1);
        global_config_one <= 1'b1;
        wr(8'h30, 8'h00, ok_resp);
        check(32'(port_pins_float), 32'h1);
        wr(8'hF0, 8'h00, ok_resp);
        check(32'(port_pins_float), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, io_cycle} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hF;
        global_config_one = 1'b1;
        second_level_ext_ctl_bit4 = 1'b0;
        ecr_mode = 3'h0;
        io_addr = 16'h0000;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_ext();
        t_epp();
        t_readonly();
        t_modes();
        t_power();
        wrap_up();
    end
endmodule
